//--- dv/relay_spi_frame_chk.sv
// Port assertions of the serial frame slave
`timescale 1ns/1ps
module relay_spi_frame_chk (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE_N,
  input wire logic WR_VALID,
  input wire logic WR_READY,
  input wire logic WR_WIDE,
  input wire logic [5:0] WR_ADDR,
  input wire logic [9:0] WR_DATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // Two sync stages keep the pin released for two samples
  a_oe_enable: assert property ($fell(CHIP_SELECT_N) |-> SERIAL_OUT_OE_N[*2]
    ##[1:5] !SERIAL_OUT_OE_N) else $error("output enable late or early");
  a_oe_release: assert property ($rose(CHIP_SELECT_N) |-> ##[1:6] SERIAL_OUT_OE_N)
    else $error("output not released");
  a_oe_idle: assert property (CHIP_SELECT_N[*6] |-> SERIAL_OUT_OE_N)
    else $error("output driven while deselected");
  a_so_edge: assert property (!CHIP_SELECT_N && !$past(SERIAL_OUT_OE_N, 2)
    && $changed(SERIAL_OUT) |-> $past(SERIAL_CLK) || $past(SERIAL_CLK, 2))
    else $error("output changed away from rising clock");
  a_wr_hold: assert property (WR_VALID && !WR_READY |=> WR_VALID
    && $stable({WR_WIDE, WR_ADDR, WR_DATA})) else $error("write dropped");
  a_wr_after_cs: assert property ($rose(WR_VALID) |-> CHIP_SELECT_N
    && $past(CHIP_SELECT_N)) else $error("write inside a frame");
  a_wr_map: assert property (WR_VALID |-> !WR_ADDR[5] && WR_WIDE == WR_ADDR[4])
    else $error("write to wrong bank");
  a_wr_sec: assert property (WR_VALID |-> WR_DATA[9:8] == WR_ADDR[1:0])
    else $error("write address and data disagree");
endmodule
bind relay_spi_frame relay_spi_frame_chk chk (.CORE_CLK, .RESET, .CHIP_SELECT_N,
  .SERIAL_CLK, .SERIAL_OUT, .SERIAL_OUT_OE_N, .WR_VALID, .WR_READY, .WR_WIDE,
  .WR_ADDR, .WR_DATA);

//--- dv/relay_spi_frame_tb.sv
// Self-checking bench of the serial frame slave
`timescale 1ns/1ps
module relay_spi_frame_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_ready = 1'b0;
  logic stall = 1'b0;
  logic [14:0] diag = 15'h0000;
  logic chip_select_n, sclk, si, so_w, so, oe_n, stb, wr_valid, wr_wide;
  logic [5:0] wr_addr;
  logic [9:0] wr_data;
  logic [15:0] rep, pend;
  logic [7:0] regb [16];
  logic [9:0] regw [4];
  logic [31:0] exp_rep [$];
  logic [16:0] exp_wr [$];
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int ncnt [6] = '{16, 16, 24, 32, 17, 23};
  logic [21:0] tab [14] = '{22'h1086a5, 22'h1097c7, 22'h118600, 22'h184602, 22'h205402,
    22'h10c6ff, 22'h104602, 22'h100002, 22'h10a4ff, 22'h107002, 22'h104603,
    22'h0f0001, 22'h280001, 22'h080001};
  always #10 clk = ~clk;
  assign so_w = oe_n ? 1'bz : so;
  relay_spi_frame dut (.CORE_CLK(clk), .RESET(rst), .CHIP_SELECT_N(chip_select_n), .SERIAL_CLK(sclk),
    .SERIAL_IN(si), .SERIAL_OUT(so), .SERIAL_OUT_OE_N(oe_n), .DIAG_BITS(diag),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_WIDE(wr_wide), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data));
  spi_master_model m (.chip_select_n(chip_select_n), .sclk(sclk), .si(si), .so(so_w), .rep(rep), .stb(stb));
  ////////////////////////////////////////
  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic clear();
    foreach (regb[i]) regb[i] = 8'h00;
    foreach (regw[i]) regw[i] = 10'h000;
    pend = relay_spi_pkg::RESET_REPLY;
  endtask
  task automatic xfer(input logic [15:0] c, input int n);
    logic [15:0] d;
    logic ok;
    logic [3:0] p;
    int k;
    diag = 15'($urandom());
    d = {1'b0, diag};
    ok = (n == 16 || n == 24 || n == 32);
    d[10] = !ok;
    p = c[13:10];
    // Only the first 16 reply bits are caught; short frames catch fewer
    k = (n < 16) ? n : 16;
    exp_rep.push_back({16'hffff >> (16 - k), pend >> (16 - k)});
    if (!ok || (!c[15] && c[1:0] == 2'h1)) begin
      pend = d;
    end else if (c[15:14] == 2'h2 && p == relay_spi_pkg::SOFT_RESET_ADDR) begin
      clear();
    end else if (c[15:14] == 2'h2 && p < 4'h8) begin
      if (p[2]) regw[p[1:0]] = c[9:0];
      else regb[{p[1:0], c[9:8]}] = c[7:0];
      exp_wr.push_back({p[2], c[13:8], c[9:0]});
      pend = d;
    end else if (c[15:14] == 2'h1 && c[1:0] == 2'h2 && p < 4'h8) begin
      pend = p[2] ? {2'h2, p, regw[p[1:0]]} : {2'h2, c[13:8], regb[{p[1:0], c[9:8]}]};
    end else begin
      pend = relay_spi_pkg::SYNTAX_REPLY;
    end
    m.frame(c, n);
  endtask
  ////////////////////////////////////////
  always @(negedge clk) wr_ready <= !stall && ($urandom() % 4 != 0);
  always @(posedge stb) begin
    logic [31:0] e;
    e = exp_rep.pop_front();
    n_tests++;
    if ((rep & e[31:16]) !== e[15:0]) begin
      n_mismatch++;
      $display("wrong value at %0t: reply %h expected %h", $time, rep, e[15:0]);
    end
  end
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready) begin
      n_tests++;
      if (exp_wr.size() == 0 || {wr_wide, wr_addr, wr_data} !== exp_wr.pop_front()) begin
        n_mismatch++;
        $display("wrong value at %0t: write %h %h", $time, wr_addr, wr_data);
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////
  initial begin
    logic [15:0] c;
    void'($urandom(83));
    clear();
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    xfer(16'h0001, 16);
    foreach (tab[i]) xfer(tab[i][15:0], int'(tab[i][21:16]));
    // Sink stalls so both buffer places fill
    stall = 1'b1;
    xfer(16'h8bff, 16);
    xfer(16'h9c00, 16);
    repeat (40) @(negedge clk);
    stall = 1'b0;
    repeat (60) begin
      c = 16'($urandom());
      // Software reset kept out of random traffic
      if (c[15:14] == 2'h2 && c[13:10] == 4'hf) c[13] = 1'b0;
      xfer(c, ncnt[$urandom() % 6]);
    end
    xfer(16'hbc00, 16);
    xfer(16'h4602, 16);
    xfer(16'h0001, 16);
    repeat (40) @(negedge clk);
    n_tests++;
    if (exp_wr.size() != 0) begin
      n_mismatch++;
      $display("wrong value at %0t: expected write never seen", $time);
    end
    rst = 1'b1;
    clear();
    repeat (6) @(negedge clk);
    rst = 1'b0;
    xfer(16'h4602, 24);
    xfer(16'h0001, 16);
    xfer(16'h0001, 16);
    repeat (20) @(negedge clk);
    test_done();
  end
endmodule

//--- dv/spi_master_model.sv
// Frame master model on the serial side
`timescale 1ns/1ps
module spi_master_model (
  output logic chip_select_n,
  output logic sclk,
  output logic si,
  input wire logic so,
  output logic [15:0] rep,
  output logic stb
);
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    rep = 16'h0000;
    stb = 1'b0;
  end
  // Clock and data rest low between frames, driven low by this model
  task automatic frame(input logic [15:0] c, input int n);
    chip_select_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      if (n - 1 - i < 16) rep = {rep[14:0], so};
      si = (i < 16) ? c[i] : 1'b0;
      sclk = 1'b1;
      #80 sclk = 1'b0;
      #80;
    end
    si = 1'b0;
    #200 chip_select_n = 1'b1;
    stb = 1'b1;
    // Long gap also lets a stalled evaluation finish
    #400 stb = 1'b0;
  endtask
endmodule

//--- rtl/relay_spi_frame.sv
// Serial frame slave of the relay driver: shifting, decoding and replies
`timescale 1ns/1ps
module relay_spi_frame (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE_N,
  input wire logic [14:0] DIAG_BITS,
  output logic WR_VALID,
  input wire logic WR_READY,
  output logic WR_WIDE,
  output logic [5:0] WR_ADDR,
  output logic [9:0] WR_DATA
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic cs_s1_q;
  logic cs_s2_q;
  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_prev_q;
  logic si_s1_q;
  logic si_s2_q;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_prev_q <= 1'b0;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= CHIP_SELECT_N;
      cs_s2_q <= cs_s1_q;
      sck_s1_q <= SERIAL_CLK;
      sck_s2_q <= sck_s1_q;
      sck_prev_q <= sck_s2_q;
      si_s1_q <= SERIAL_IN;
      si_s2_q <= si_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame state

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_EVAL} state_t;

  state_t state_q;
  state_t state_d;
  logic [15:0] in_shift_q;
  logic [15:0] in_shift_d;
  logic [15:0] out_shift_q;
  logic [15:0] out_shift_d;
  logic [15:0] reply_q;
  logic [15:0] reply_d;
  logic [5:0] clk_cnt_q;
  logic [5:0] clk_cnt_d;
  logic [7:0] byte_mem_q [relay_spi_pkg::BYTE_REGS];
  logic [7:0] byte_mem_d [relay_spi_pkg::BYTE_REGS];
  logic [9:0] word_mem_q [relay_spi_pkg::WORD_REGS];
  logic [9:0] word_mem_d [relay_spi_pkg::WORD_REGS];
  logic wr_push;
  logic wr_in_ready;
  logic [relay_spi_pkg::WR_ENTRY_BITS-1:0] wr_entry;
  logic [relay_spi_pkg::WR_ENTRY_BITS-1:0] wr_out_entry;

  logic sck_fall;
  logic sck_rise;

  assign sck_fall = sck_prev_q && !sck_s2_q && !cs_s2_q;
  assign sck_rise = !sck_prev_q && sck_s2_q && !cs_s2_q;

  function automatic relay_spi_pkg::addr_class_t addr_class(input logic [3:0] prim);
    if (prim <= relay_spi_pkg::BYTE_ADDR_LAST) begin
      addr_class = relay_spi_pkg::CLS_BYTE;
    end else if (prim >= relay_spi_pkg::WORD_ADDR_FIRST &&
                 prim <= relay_spi_pkg::WORD_ADDR_LAST) begin
      addr_class = relay_spi_pkg::CLS_WORD;
    end else if (prim == relay_spi_pkg::SOFT_RESET_ADDR) begin
      addr_class = relay_spi_pkg::CLS_SOFT_RESET;
    end else begin
      addr_class = relay_spi_pkg::CLS_RESERVED;
    end
  endfunction

  always_comb begin
    logic [15:0] cmd;
    logic [3:0] prim;
    logic [1:0] sec;
    logic frame_ok;
    logic [15:0] diag;
    relay_spi_pkg::addr_class_t cls;
    cmd = in_shift_q;
    prim = in_shift_q[13:10];
    sec = in_shift_q[9:8];
    cls = addr_class(prim);
    frame_ok = clk_cnt_q >= relay_spi_pkg::FRAME_MIN_CLKS &&
               clk_cnt_q <= relay_spi_pkg::FRAME_MAX_CLKS &&
               (clk_cnt_q[2:0] & relay_spi_pkg::BYTE_ALIGN_MASK) == 3'h0;
    diag = {1'b0, DIAG_BITS};
    // Flags the frame just ended; its reply goes out one frame later
    diag[relay_spi_pkg::TER_BIT] = !frame_ok;
    state_d = state_q;
    in_shift_d = in_shift_q;
    out_shift_d = out_shift_q;
    reply_d = reply_q;
    clk_cnt_d = clk_cnt_q;
    byte_mem_d = byte_mem_q;
    word_mem_d = word_mem_q;
    wr_push = 1'b0;
    wr_entry = {prim, sec, cmd[9:0], cls == relay_spi_pkg::CLS_WORD};
    case (state_q)
      ST_IDLE: begin
        if (!cs_s2_q) begin
          out_shift_d = reply_q;
          clk_cnt_d = 6'h0;
          state_d = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (sck_fall) begin
          in_shift_d = {in_shift_q[14:0], si_s2_q};
          if (clk_cnt_q != relay_spi_pkg::CLK_COUNT_MAX) begin
            clk_cnt_d = clk_cnt_q + 6'h1;
          end
        end
        if (sck_rise) begin
          out_shift_d = {out_shift_q[14:0], 1'b0};
        end
        if (cs_s2_q) begin
          state_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        state_d = ST_IDLE;
        if (!frame_ok) begin
          reply_d = diag;
          reply_d[relay_spi_pkg::TER_BIT] = 1'b1;
        end else if (cmd[15:14] == relay_spi_pkg::LEAD_WRITE) begin
          if (cls == relay_spi_pkg::CLS_RESERVED) begin
            reply_d = relay_spi_pkg::SYNTAX_REPLY;
          end else if (cls == relay_spi_pkg::CLS_SOFT_RESET) begin
            reply_d = relay_spi_pkg::RESET_REPLY;
            for (int i = 0; i < relay_spi_pkg::BYTE_REGS; i++) begin
              byte_mem_d[i] = 8'h00;
            end
            for (int i = 0; i < relay_spi_pkg::WORD_REGS; i++) begin
              word_mem_d[i] = 10'h000;
            end
          end else if (!wr_in_ready) begin
            state_d = ST_EVAL; // Hold the frame until the write can be reported
          end else begin
            wr_push = 1'b1;
            reply_d = diag;
            if (cls == relay_spi_pkg::CLS_WORD) begin
              word_mem_d[prim[1:0]] = cmd[9:0];
            end else begin
              byte_mem_d[{prim[1:0], sec}] = cmd[7:0];
            end
          end
        end else if (cmd[15] == 1'b0 && cmd[1:0] == relay_spi_pkg::TAIL_DIAG) begin
          reply_d = diag;
        end else if (cmd[15:14] != relay_spi_pkg::LEAD_READ) begin
          reply_d = relay_spi_pkg::SYNTAX_REPLY;
        end else if (cmd[1:0] != relay_spi_pkg::TAIL_REG ||
                     cls == relay_spi_pkg::CLS_RESERVED ||
                     cls == relay_spi_pkg::CLS_SOFT_RESET) begin
          reply_d = relay_spi_pkg::SYNTAX_REPLY;
        end else if (cls == relay_spi_pkg::CLS_WORD) begin
          reply_d = {relay_spi_pkg::REPLY_REG_LEAD, prim, word_mem_q[prim[1:0]]};
        end else begin
          reply_d = {relay_spi_pkg::REPLY_REG_LEAD, prim, sec,
                     byte_mem_q[{prim[1:0], sec}]};
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      in_shift_q <= 16'h0000;
      out_shift_q <= 16'h0000;
      reply_q <= relay_spi_pkg::RESET_REPLY;
      clk_cnt_q <= 6'h00;
      for (int i = 0; i < relay_spi_pkg::BYTE_REGS; i++) begin
        byte_mem_q[i] <= 8'h00;
      end
      for (int i = 0; i < relay_spi_pkg::WORD_REGS; i++) begin
        word_mem_q[i] <= 10'h000;
      end
    end else begin
      state_q <= state_d;
      in_shift_q <= in_shift_d;
      out_shift_q <= out_shift_d;
      reply_q <= reply_d;
      clk_cnt_q <= clk_cnt_d;
      byte_mem_q <= byte_mem_d;
      word_mem_q <= word_mem_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Released by the synchronised select, so release lags the pin by 1-2 cycles
  assign SERIAL_OUT = out_shift_q[15];
  assign SERIAL_OUT_OE_N = cs_s2_q || state_q != ST_FRAME;

  relay_wr_buffer #(
    .WIDTH(relay_spi_pkg::WR_ENTRY_BITS),
    .DEPTH(relay_spi_pkg::WR_BUF_DEPTH)
  ) wr_buf (
    .clk(CORE_CLK),
    .rst(RESET),
    .in_valid(wr_push),
    .in_ready(wr_in_ready),
    .in_data(wr_entry),
    .out_valid(WR_VALID),
    .out_ready(WR_READY),
    .out_data(wr_out_entry)
  );

  assign WR_ADDR = wr_out_entry[16:11];
  assign WR_DATA = wr_out_entry[10:1];
  assign WR_WIDE = wr_out_entry[0];

endmodule

//--- rtl/relay_spi_pkg.sv
// Shared constants and types of the relay driver frame interface
package relay_spi_pkg;

  localparam int FRAME_BITS = 16;
  localparam logic [5:0] FRAME_MIN_CLKS = 6'h10;
  localparam logic [5:0] FRAME_MAX_CLKS = 6'h20;
  localparam logic [5:0] CLK_COUNT_MAX = 6'h3f;
  localparam logic [2:0] BYTE_ALIGN_MASK = 3'h7;

  // Leading command bits
  localparam logic [1:0] LEAD_WRITE = 2'h2;
  localparam logic [1:0] LEAD_READ = 2'h1;
  // Trailing bits of a read
  localparam logic [1:0] TAIL_DIAG = 2'h1;
  localparam logic [1:0] TAIL_REG = 2'h2;
  // Leading bits of a register content reply
  localparam logic [1:0] REPLY_REG_LEAD = 2'h2;

  localparam int TER_BIT = 10;

  // Address map of the local register banks
  localparam logic [3:0] BYTE_ADDR_LAST = 4'h3;
  localparam logic [3:0] WORD_ADDR_FIRST = 4'h4;
  localparam logic [3:0] WORD_ADDR_LAST = 4'h7;
  localparam logic [3:0] SOFT_RESET_ADDR = 4'hf;
  localparam int BYTE_REGS = 16;
  localparam int WORD_REGS = 4;

  // Arbitrary fixed reply words
  localparam logic [15:0] RESET_REPLY = 16'h4400;
  localparam logic [15:0] SYNTAX_REPLY = 16'h4000;

  localparam int WR_ENTRY_BITS = 17;
  localparam int WR_BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    CLS_BYTE,
    CLS_WORD,
    CLS_SOFT_RESET,
    CLS_RESERVED
  } addr_class_t;

endpackage

//--- rtl/relay_wr_buffer.sv
// Two-entry valid/ready buffer for register write notifications
`timescale 1ns/1ps
module relay_wr_buffer #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic rd_ptr_q;
  logic rd_ptr_d;
  logic wr_ptr_q;
  logic wr_ptr_d;
  logic [1:0] fill_q;
  logic [1:0] fill_d;
  logic push;
  logic pop;

  assign in_ready = fill_q != 2'(DEPTH);
  assign out_valid = fill_q != 2'h0;
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    rd_ptr_d = rd_ptr_q;
    wr_ptr_d = wr_ptr_q;
    fill_d = fill_q;
    if (push) begin
      mem_d[wr_ptr_q] = in_data;
      wr_ptr_d = ~wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = ~rd_ptr_q;
    end
    if (push && !pop) begin
      fill_d = fill_q + 2'h1;
    end else if (pop && !push) begin
      fill_d = fill_q - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      fill_q <= 2'h0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      rd_ptr_q <= rd_ptr_d;
      wr_ptr_q <= wr_ptr_d;
      fill_q <= fill_d;
      mem_q <= mem_d;
    end
  end

endmodule
